// File: hdl/pss_pkg.sv
// pss_pkg: constants, field layout and carrier types of the phy status summary block.
// assumes: 32-bit APB, register index times four is the byte address.
package pss_pkg;

    // ***************************************************
    // register indices (byte address is index * 4)
    // ***************************************************
    localparam int unsigned PSS_PADDR_W = 12;
    localparam logic [7:0] PSS_IDX_BASIC = 8'h01;
    localparam logic [7:0] PSS_IDX_ANEXP = 8'h06;
    localparam logic [7:0] PSS_IDX_SUMMARY = 8'h10;
    localparam logic [7:0] PSS_IDX_FALSE = 8'h14;
    localparam logic [7:0] PSS_IDX_RXERR = 8'h15;
    localparam logic [7:0] PSS_IDX_TENBASE = 8'h1A;

    // ***************************************************
    // summary word field positions
    // ***************************************************
    localparam int unsigned PSS_SUM_RSVD_HI = 15;
    localparam int unsigned PSS_SUM_RSVD_LO = 14;
    localparam int unsigned PSS_SUM_RXERR = 13;
    localparam int unsigned PSS_SUM_POL = 12;
    localparam int unsigned PSS_SUM_FALSE = 11;
    localparam int unsigned PSS_SUM_SIGDET = 10;
    localparam int unsigned PSS_SUM_DESCLK = 9;
    localparam int unsigned PSS_SUM_PAGE = 8;
    localparam int unsigned PSS_SUM_RSVD7 = 7;
    localparam int unsigned PSS_SUM_RFAULT = 6;
    localparam int unsigned PSS_SUM_JABBER = 5;
    localparam int unsigned PSS_SUM_ANDONE = 4;
    localparam int unsigned PSS_SUM_LOOP = 3;
    localparam int unsigned PSS_SUM_DUPLEX = 2;
    localparam int unsigned PSS_SUM_SPEED10 = 1;
    localparam int unsigned PSS_SUM_LINK = 0;

    // ***************************************************
    // source register field positions
    // ***************************************************
    localparam int unsigned PSS_BAS_RFAULT = 4;
    localparam int unsigned PSS_BAS_ANDONE = 5;
    localparam int unsigned PSS_BAS_LINK = 2;
    localparam int unsigned PSS_BAS_JABBER = 1;
    localparam int unsigned PSS_ANE_PAGE = 1;
    localparam int unsigned PSS_TEN_POL = 4;

    // ***************************************************
    // reset values and limits
    // ***************************************************
    localparam logic [15:0] PSS_SUM_RESET = 16'h0000;
    localparam logic [7:0] PSS_CNT_RESET = 8'h00;
    localparam logic [7:0] PSS_CNT_MAX = 8'hFF;
    localparam logic [7:0] PSS_CNT_ONE = 8'h01;
    localparam logic [31:0] PSS_RDATA_RESET = 32'h0000_0000;

    // ***************************************************
    // types
    // ***************************************************
    typedef enum logic [1:0] {
        PSS_IDLE = 2'b01,
        PSS_RESP = 2'b10
    } pss_apb_e;

    // level indications from the pmd and the negotiation logic
    typedef struct packed {
        logic signalDetect;
        logic descramLock;
        logic anComplete;
        logic loopbackEn;
        logic fullDuplex;
        logic speed10;
        logic linkUp;
    } pss_lvl_s;

    // one-cycle event pulses on clk
    typedef struct packed {
        logic rxError;
        logic falseCarrier;
        logic pageRx;
        logic remoteFault;
        logic polarityInv;
        logic jabber;
    } pss_evt_s;

    typedef struct packed {
        pss_lvl_s stage1;
        pss_lvl_s stage2;
    } pss_sync_s;

    typedef struct packed {
        logic q;
    } pss_latch_s;

    typedef struct packed {
        pss_apb_e phase;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] cntRxErr;
        logic [7:0] cntFalse;
    } pss_state_s;

endpackage

// File: hdl/pss_sync2.sv
// pss_sync2: two-flop synchroniser for the level indications.
// assumes: inputs come from outside the clk domain.
`timescale 1ns/1ps
module pss_sync2 import pss_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire pss_lvl_s asyncIn,
    output pss_lvl_s syncOut
);

    pss_sync_s st_ff;
    pss_sync_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.stage1 = asyncIn;
        nxt_st.stage2 = st_ff.stage1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign syncOut = st_ff.stage2;

endmodule

// File: hdl/pss_latch.sv
// pss_latch: one latching status bit, latch-high or latch-low.
// assumes: src and clr are on clk; set wins over clear.
`timescale 1ns/1ps
module pss_latch import pss_pkg::*; #(
    parameter bit LATCH_LOW = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic src,
    input wire logic clr,
    output logic q
);

    pss_latch_s st_ff;
    pss_latch_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (LATCH_LOW) begin
            // refresh on clear, otherwise hold any low seen
            nxt_st.q = clr ? src : (st_ff.q & src);
        end else begin
            nxt_st.q = src | (st_ff.q & ~clr);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;

endmodule

// File: hdl/pss_status_summary.sv
// pss_status_summary: apb slave holding the phy status summary word and its source flags.
// assumes: apb master on clk; event pulses on clk; level indications asynchronous.
//
// Overview of operation
// RL1: bits 15:14 read zero, writes ignored
// RL2: bit 13 latches rx error, cleared by counter read
// RL3: bit 12 mirrors polarity, cleared by tenbase read
// RL4: bit 11 latches false carrier until counter read
// RL5: bit 10 signal detect, latch low, reset zero
// RL6: bit 9 descrambler lock, latch low, reset zero
// RL7: bit 8 mirrors page received, expansion read clears
// RL8: bit 7 reads zero, writes ignored
// RL9: bit 6 remote fault, cleared by basic read
// RL10: bit 5 mirrors jabber, summary read keeps it
// RL11: bit 4 shows negotiation complete
// RL12: bit 3 shows loopback enabled
// RL13: bit 2 shows resolved duplex, 1 full
// RL14: bit 1 shows resolved speed, 1 is 10
// RL15: software trusts duplex/speed only with valid link
// RL16: bit 0 mirrors link status, not cleared here
// RL17: page flag sets on code word, read clears
// RL18: summary read changes no bit anywhere
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module pss_status_summary import pss_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PSS_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pss_lvl_s phyLevels,
    input wire pss_evt_s phyEvents
);

    // ***************************************************
    // helpers
    // ***************************************************
    // saturating counter that clears on read and loads on write
    function automatic logic [7:0] pss_count_next(
        input logic [7:0] cnt,
        input logic evt,
        input logic rd,
        input logic wr,
        input logic [7:0] wval
    );
        logic [7:0] res;
        res = cnt;
        if (rd) begin
            res = evt ? PSS_CNT_ONE : PSS_CNT_RESET;
        end else if (wr) begin
            res = wval;
        end else if (evt && (cnt != PSS_CNT_MAX)) begin
            res = cnt + PSS_CNT_ONE;
        end
        return res;
    endfunction

    // ***************************************************
    // state and decode
    // ***************************************************
    pss_state_s st_ff;
    pss_state_s nxt_st;
    pss_lvl_s lvlSync;
    logic aligned;
    logic [7:0] regIdx;
    logic hit;
    logic accessDone;
    logic rdDone;
    logic wrDone;
    logic rdBasic;
    logic rdAnexp;
    logic rdFalse;
    logic rdRxErr;
    logic rdTenbase;
    logic rdSummary;
    logic latRxErr;
    logic latFalse;
    logic latPage;
    logic latRFault;
    logic latJabber;
    logic latPol;
    logic latSigDet;
    logic latDescLock;
    logic [15:0] summaryWord;
    logic [15:0] basicWord;
    logic [15:0] anexpWord;
    logic [15:0] tenbaseWord;
    logic [31:0] readMux;

    assign aligned = (paddr[1:0] == 2'b00) && (paddr[PSS_PADDR_W-1:10] == '0);
    assign regIdx = paddr[9:2];
    assign hit = aligned && (regIdx == PSS_IDX_BASIC || regIdx == PSS_IDX_ANEXP ||
        regIdx == PSS_IDX_SUMMARY || regIdx == PSS_IDX_FALSE ||
        regIdx == PSS_IDX_RXERR || regIdx == PSS_IDX_TENBASE);

    // side effects happen only on the edge that completes the access
    assign accessDone = psel && penable && st_ff.pready && hit;
    assign rdDone = accessDone && !pwrite;
    assign wrDone = accessDone && pwrite;
    assign rdBasic = rdDone && (regIdx == PSS_IDX_BASIC);
    assign rdAnexp = rdDone && (regIdx == PSS_IDX_ANEXP);
    assign rdFalse = rdDone && (regIdx == PSS_IDX_FALSE);
    assign rdRxErr = rdDone && (regIdx == PSS_IDX_RXERR);
    assign rdTenbase = rdDone && (regIdx == PSS_IDX_TENBASE);
    assign rdSummary = rdDone && (regIdx == PSS_IDX_SUMMARY);

    // ***************************************************
    // level inputs and latched flags
    // ***************************************************
    pss_sync2 u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .asyncIn(phyLevels),
        .syncOut(lvlSync)
    );

    pss_latch #(.LATCH_LOW(1'b0)) u_rxerr (  // [RL2]
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .src(phyEvents.rxError), .clr(rdRxErr), .q(latRxErr)
    );
    pss_latch #(.LATCH_LOW(1'b0)) u_false (  // [RL4]
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .src(phyEvents.falseCarrier), .clr(rdFalse), .q(latFalse)
    );
    pss_latch #(.LATCH_LOW(1'b0)) u_page (  // [RL17]
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .src(phyEvents.pageRx), .clr(rdAnexp), .q(latPage)
    );
    pss_latch #(.LATCH_LOW(1'b0)) u_rfault (  // [RL9]
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .src(phyEvents.remoteFault), .clr(rdBasic), .q(latRFault)
    );
    pss_latch #(.LATCH_LOW(1'b0)) u_jabber (  // [RL10]
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .src(phyEvents.jabber), .clr(rdBasic), .q(latJabber)
    );
    pss_latch #(.LATCH_LOW(1'b0)) u_pol (  // [RL3]
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .src(phyEvents.polarityInv), .clr(rdTenbase), .q(latPol)
    );
    pss_latch #(.LATCH_LOW(1'b1)) u_sigdet (  // [RL5]
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .src(lvlSync.signalDetect), .clr(rdBasic), .q(latSigDet)
    );
    pss_latch #(.LATCH_LOW(1'b1)) u_desclk (  // [RL6]
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .src(lvlSync.descramLock), .clr(rdBasic), .q(latDescLock)
    );

    // ***************************************************
    // register words
    // ***************************************************
    always_comb begin
        summaryWord = PSS_SUM_RESET;  // [RL1] [RL8]
        summaryWord[PSS_SUM_RXERR] = latRxErr;  // [RL2]
        summaryWord[PSS_SUM_POL] = latPol;  // [RL3]
        summaryWord[PSS_SUM_FALSE] = latFalse;  // [RL4]
        summaryWord[PSS_SUM_SIGDET] = latSigDet;  // [RL5]
        summaryWord[PSS_SUM_DESCLK] = latDescLock;  // [RL6]
        summaryWord[PSS_SUM_PAGE] = latPage;  // [RL7]
        summaryWord[PSS_SUM_RFAULT] = latRFault;  // [RL9]
        summaryWord[PSS_SUM_JABBER] = latJabber;  // [RL10]
        summaryWord[PSS_SUM_ANDONE] = lvlSync.anComplete;  // [RL11]
        summaryWord[PSS_SUM_LOOP] = lvlSync.loopbackEn;  // [RL12]
        summaryWord[PSS_SUM_DUPLEX] = lvlSync.fullDuplex;  // [RL13]
        summaryWord[PSS_SUM_SPEED10] = lvlSync.speed10;  // [RL14]
        summaryWord[PSS_SUM_LINK] = lvlSync.linkUp;  // [RL16]
    end

    always_comb begin
        basicWord = PSS_SUM_RESET;
        basicWord[PSS_BAS_RFAULT] = latRFault;
        basicWord[PSS_BAS_ANDONE] = lvlSync.anComplete;
        basicWord[PSS_BAS_LINK] = lvlSync.linkUp;
        basicWord[PSS_BAS_JABBER] = latJabber;
        anexpWord = PSS_SUM_RESET;
        anexpWord[PSS_ANE_PAGE] = latPage;
        tenbaseWord = PSS_SUM_RESET;
        tenbaseWord[PSS_TEN_POL] = latPol;
    end

    always_comb begin
        readMux = PSS_RDATA_RESET;
        unique case (regIdx)
            PSS_IDX_BASIC: readMux[15:0] = basicWord;
            PSS_IDX_ANEXP: readMux[15:0] = anexpWord;
            PSS_IDX_SUMMARY: readMux[15:0] = summaryWord;
            PSS_IDX_FALSE: readMux[7:0] = st_ff.cntFalse;
            PSS_IDX_RXERR: readMux[7:0] = st_ff.cntRxErr;
            PSS_IDX_TENBASE: readMux[15:0] = tenbaseWord;
            default: readMux = PSS_RDATA_RESET;
        endcase
    end

    // ***************************************************
    // apb slave and counters
    // ***************************************************
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff.phase)
            PSS_IDLE: begin
                if (psel && !penable) begin
                    nxt_st.phase = PSS_RESP;
                    nxt_st.pready = 1'b1;
                    nxt_st.pslverr = !hit;
                    nxt_st.prdata = (hit && !pwrite) ? readMux : PSS_RDATA_RESET;
                end
            end
            PSS_RESP: begin
                nxt_st.phase = PSS_IDLE;
                nxt_st.pready = 1'b0;
                nxt_st.pslverr = 1'b0;
                nxt_st.prdata = PSS_RDATA_RESET;
            end
        endcase
        // writes reach only the counters; the summary word stays read-only
        nxt_st.cntRxErr = pss_count_next(st_ff.cntRxErr, phyEvents.rxError, rdRxErr,
            wrDone && (regIdx == PSS_IDX_RXERR) && pstrb[0], pwdata[7:0]);
        nxt_st.cntFalse = pss_count_next(st_ff.cntFalse, phyEvents.falseCarrier, rdFalse,
            wrDone && (regIdx == PSS_IDX_FALSE) && pstrb[0], pwdata[7:0]);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff.phase <= PSS_IDLE;
            st_ff.pready <= 1'b0;
            st_ff.pslverr <= 1'b0;
            st_ff.prdata <= PSS_RDATA_RESET;
            st_ff.cntRxErr <= PSS_CNT_RESET;
            st_ff.cntFalse <= PSS_CNT_RESET;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;

    // ***************************************************
    // checks
    // ***************************************************
    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!arst_n)  // [RL1] [RL8]
        (summaryWord[PSS_SUM_RSVD_HI:PSS_SUM_RSVD_LO] == 2'b00) && !summaryWord[PSS_SUM_RSVD7])
        else $error("reserved summary bits not zero");

    AST_RXERR_SET: assert property (@(posedge clk) disable iff (!arst_n)  // [RL2]
        ce && phyEvents.rxError |=> summaryWord[PSS_SUM_RXERR])
        else $error("rx error event not latched");

    AST_RXERR_HOLD: assert property (@(posedge clk) disable iff (!arst_n)  // [RL2]
        ce && latRxErr && !rdRxErr |=> latRxErr)
        else $error("rx error latch cleared without counter read");

    AST_POL_KEEP: assert property (@(posedge clk) disable iff (!arst_n)  // [RL3]
        ce && latPol && !rdTenbase |=> summaryWord[PSS_SUM_POL])
        else $error("polarity bit lost without tenbase read");

    AST_FALSE_SET: assert property (@(posedge clk) disable iff (!arst_n)  // [RL4]
        ce && phyEvents.falseCarrier |=> latFalse && (st_ff.cntFalse != PSS_CNT_RESET))
        else $error("false carrier event not latched or counted");

    AST_SIGDET_LL: assert property (@(posedge clk) disable iff (!arst_n)  // [RL5]
        ce && !lvlSync.signalDetect |=> !summaryWord[PSS_SUM_SIGDET])
        else $error("signal detect low not latched");

    AST_DESCLK_LL: assert property (@(posedge clk) disable iff (!arst_n)  // [RL6]
        ce && !latDescLock && !rdBasic |=> !summaryWord[PSS_SUM_DESCLK])
        else $error("descrambler lock latch released without refresh");

    AST_PAGE_HOLD: assert property (@(posedge clk) disable iff (!arst_n)  // [RL7] [RL17]
        ce && latPage && !rdAnexp |=> summaryWord[PSS_SUM_PAGE])
        else $error("page received cleared without expansion read");

    AST_RFAULT_CLR: assert property (@(posedge clk) disable iff (!arst_n)  // [RL9]
        ce && rdBasic && !phyEvents.remoteFault |=> !summaryWord[PSS_SUM_RFAULT])
        else $error("remote fault not cleared by basic status read");

    AST_SUMMARY_NOSIDE: assert property (@(posedge clk) disable iff (!arst_n)  // [RL18] [RL10]
        ce && rdSummary && !(|phyEvents) |=>
            summaryWord[PSS_SUM_RXERR:PSS_SUM_FALSE] == $past(summaryWord[PSS_SUM_RXERR:PSS_SUM_FALSE]) &&
            summaryWord[PSS_SUM_PAGE] == $past(summaryWord[PSS_SUM_PAGE]) &&
            summaryWord[PSS_SUM_RFAULT:PSS_SUM_JABBER] == $past(summaryWord[PSS_SUM_RFAULT:PSS_SUM_JABBER]))
        else $error("summary read disturbed a latched bit");

    AST_READ_DATA: assert property (@(posedge clk) disable iff (!arst_n)  // [RL11] [RL16]
        ce && psel && !penable && !pwrite && aligned && (regIdx == PSS_IDX_SUMMARY) && (st_ff.phase == PSS_IDLE)
            |=> pready && (prdata[15:0] == $past(summaryWord)) && (prdata[31:16] == 16'h0000))
        else $error("summary read data does not match status");

    AST_ZERO_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
        ce && pready |=> !pready)
        else $error("pready held longer than one cycle");

    AST_RXERR_CLR: assert property (@(posedge clk) disable iff (!arst_n)  // [RL2]
        ce && rdRxErr && !phyEvents.rxError |=> !latRxErr && (st_ff.cntRxErr == PSS_CNT_RESET))
        else $error("rx error latch or counter not cleared by counter read");

    AST_POL_SET: assert property (@(posedge clk) disable iff (!arst_n)  // [RL3]
        ce && phyEvents.polarityInv |=> summaryWord[PSS_SUM_POL] && tenbaseWord[PSS_TEN_POL])
        else $error("polarity event not latched");

    AST_FALSE_CLR: assert property (@(posedge clk) disable iff (!arst_n)  // [RL4]
        ce && rdFalse && !phyEvents.falseCarrier |=> !summaryWord[PSS_SUM_FALSE] && (st_ff.cntFalse == PSS_CNT_RESET))
        else $error("false carrier latch or counter not cleared by counter read");

    AST_PAGE_SET: assert property (@(posedge clk) disable iff (!arst_n)  // [RL7] [RL17]
        ce && phyEvents.pageRx |=> summaryWord[PSS_SUM_PAGE] && anexpWord[PSS_ANE_PAGE])
        else $error("page received event not latched");

    AST_RFAULT_SET: assert property (@(posedge clk) disable iff (!arst_n)  // [RL9]
        ce && phyEvents.remoteFault |=> summaryWord[PSS_SUM_RFAULT])
        else $error("remote fault event not latched");

    AST_JABBER_KEEP: assert property (@(posedge clk) disable iff (!arst_n)  // [RL10]
        ce && latJabber && !rdBasic |=> summaryWord[PSS_SUM_JABBER])
        else $error("jabber bit lost without basic status read");

    AST_LEVEL_MIRROR: assert property (@(posedge clk) disable iff (!arst_n)  // [RL11] [RL12] [RL13] [RL14] [RL16]
        arst_n && ce ##1 ce |=> (summaryWord[PSS_SUM_ANDONE:PSS_SUM_LINK] == $past(phyLevels[4:0], 2)))
        else $error("live status bits do not follow the levels after two flops");

    AST_DESCLK_REFRESH: assert property (@(posedge clk) disable iff (!arst_n)  // [RL6]
        ce && rdBasic |=> summaryWord[PSS_SUM_DESCLK] == $past(lvlSync.descramLock))
        else $error("descrambler lock not refreshed by basic status read");

    AST_BAD_ADDR: assert property (@(posedge clk) disable iff (!arst_n)
        ce && psel && !penable && !hit && (st_ff.phase == PSS_IDLE)
            |=> pready && pslverr && (prdata == PSS_RDATA_RESET))
        else $error("unmapped access not refused");

    AST_COUNT_SAT: assert property (@(posedge clk) disable iff (!arst_n)
        ce && (st_ff.cntRxErr == PSS_CNT_MAX) && !accessDone |=> (st_ff.cntRxErr == PSS_CNT_MAX))
        else $error("rx error counter left its maximum without access");

    AST_CE_FREEZE: assert property (@(posedge clk) disable iff (!arst_n)
        !ce |=> $stable(st_ff) && $stable(summaryWord))
        else $error("state changed while clock enable low");

endmodule

// File: sim/pss_status_summary_tb_top.sv
// pss_status_summary_tb_top: self-checking bench for the phy status summary block.
// assumes: zero-wait apb slave, levels pass two flops, event pulses on clk, ce high except in the clock enable check.
`timescale 1ns/1ps
module pss_status_summary_tb_top import pss_pkg::*; ;

    typedef struct packed {
        pss_lvl_s lvl;
        logic [15:0] sum;
    } pss_lvl_row_s;

    typedef struct packed {
        pss_evt_s evt;
        logic [15:0] sum;
        logic [7:0] idx;
        logic [15:0] src;
    } pss_evt_row_s;

    logic clk, arst_n, ce, psel, penable, pwrite, pready, pslverr;
    logic [PSS_PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    pss_lvl_s phyLevels;
    pss_evt_s phyEvents;
    int n_errors;
    int comparisons;
    logic [31:0] rdData;
    logic rdErr;

    // levels in, summary word expected after a basic status read refreshed the latch-low bits
    pss_lvl_row_s lvlRows [9] = '{'{7'h01, 16'h0001}, '{7'h02, 16'h0002}, '{7'h04, 16'h0004},
        '{7'h08, 16'h0008}, '{7'h10, 16'h0010}, '{7'h40, 16'h0400}, '{7'h20, 16'h0200},
        '{7'h7F, 16'h061F}, '{7'h00, 16'h0000}};
    // event, summary bit, clearing register, its read value
    pss_evt_row_s evRows [6] = '{'{6'h20, 16'h2000, PSS_IDX_RXERR, 16'h0001},
        '{6'h10, 16'h0800, PSS_IDX_FALSE, 16'h0001}, '{6'h08, 16'h0100, PSS_IDX_ANEXP, 16'h0002},
        '{6'h04, 16'h0040, PSS_IDX_BASIC, 16'h0010}, '{6'h02, 16'h1000, PSS_IDX_TENBASE, 16'h0010},
        '{6'h01, 16'h0020, PSS_IDX_BASIC, 16'h0002}};

    pss_status_summary dut (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .phyLevels(phyLevels),
        .phyEvents(phyEvents)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ***************************************************
    // shared tasks
    // ***************************************************
    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer: setup, then access held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [PSS_PADDR_W-1:0] addr, input logic [31:0] wd);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (i == 16) begin
            n_errors++;
            $display("mismatch pready expected 1 seen 0");
            conclude();
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdReg(input logic [7:0] idx, input logic [15:0] exp, input string what);
        apb(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000);
        check(what, {16'h0000, exp}, rdData);
        check("pslverr", 32'h0000_0000, {31'h0000_0000, rdErr});
    endtask

    task automatic pulse(input pss_evt_s m);
        @(posedge clk);
        phyEvents <= m;
        @(posedge clk);
        phyEvents <= 6'h00;
    endtask

    task automatic setLvl(input pss_lvl_s v);
        @(posedge clk);
        phyLevels <= v;
        repeat (3) @(posedge clk);
    endtask

    // ***************************************************
    // main sequence
    // ***************************************************
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        phyLevels = 7'h00;
        phyEvents = 6'h00;
        n_errors = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        check("prdata in reset", 32'h0000_0000, prdata);
        arst_n <= 1'b1;
        rdReg(PSS_IDX_SUMMARY, 16'h0000, "summary after reset");
        for (int r = 0; r < 9; r++) begin
            setLvl(lvlRows[r].lvl);
            apb(1'b0, {2'b00, PSS_IDX_BASIC, 2'b00}, 32'h0000_0000);
            rdReg(PSS_IDX_SUMMARY, lvlRows[r].sum, "summary levels");
        end
        for (int e = 0; e < 6; e++) begin
            pulse(evRows[e].evt);
            rdReg(PSS_IDX_SUMMARY, evRows[e].sum, "summary latched");
            rdReg(PSS_IDX_SUMMARY, evRows[e].sum, "summary kept");
            rdReg(evRows[e].idx, evRows[e].src, "source register");
            rdReg(PSS_IDX_SUMMARY, 16'h0000, "summary cleared");
        end
        // every source set at once, then a write attempt on the read-only word
        setLvl(7'h7F);
        rdReg(PSS_IDX_BASIC, 16'h0024, "basic levels");
        pulse(6'h3F);
        rdReg(PSS_IDX_SUMMARY, 16'h3F7F, "summary all set");
        apb(1'b1, {2'b00, PSS_IDX_SUMMARY, 2'b00}, 32'hFFFF_FFFF);
        check("write pslverr", 32'h0000_0000, {31'h0000_0000, rdErr});
        rdReg(PSS_IDX_SUMMARY, 16'h3F7F, "summary after write");
        // a short drop of the pmd levels must stay latched low
        setLvl(7'h1F);
        setLvl(7'h7F);
        rdReg(PSS_IDX_SUMMARY, 16'h397F, "latch low held");
        rdReg(PSS_IDX_BASIC, 16'h0036, "basic with faults");
        rdReg(PSS_IDX_SUMMARY, 16'h3F1F, "after basic read");
        // receive error held high for many cycles saturates the counter
        @(posedge clk);
        phyEvents <= 6'h20;
        repeat (260) @(posedge clk);
        phyEvents <= 6'h00;
        rdReg(PSS_IDX_RXERR, 16'h00FF, "rx error count");
        rdReg(PSS_IDX_FALSE, 16'h0001, "false carrier count");
        rdReg(PSS_IDX_ANEXP, 16'h0002, "expansion");
        rdReg(PSS_IDX_TENBASE, 16'h0010, "tenbase");
        rdReg(PSS_IDX_SUMMARY, 16'h061F, "summary flags cleared");
        // a software load of a counter reads back, then the read clears it
        apb(1'b1, {2'b00, PSS_IDX_FALSE, 2'b00}, 32'h0000_00A5);
        check("load pslverr", 32'h0000_0000, {31'h0000_0000, rdErr});
        rdReg(PSS_IDX_FALSE, 16'h00A5, "false carrier load");
        rdReg(PSS_IDX_FALSE, 16'h0000, "false carrier cleared");
        // unmapped index and misaligned address are refused
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        check("unmapped pslverr", 32'h0000_0001, {31'h0000_0000, rdErr});
        check("unmapped prdata", 32'h0000_0000, rdData);
        apb(1'b0, 12'h041, 32'h0000_0000);
        check("misaligned pslverr", 32'h0000_0001, {31'h0000_0000, rdErr});
        // with the clock enable low an event pulse is ignored
        @(posedge clk);
        ce <= 1'b0;
        pulse(6'h20);
        @(posedge clk);
        ce <= 1'b1;
        rdReg(PSS_IDX_SUMMARY, 16'h061F, "summary with clock held");
        rdReg(PSS_IDX_RXERR, 16'h0000, "rx error count held");
        // reset in mid-run clears latches and the latch-low bits
        pulse(6'h24);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdReg(PSS_IDX_SUMMARY, 16'h001F, "summary after second reset");
        conclude();
    end

endmodule
